/* logic/tci_pkg.sv */
// Shared constants and carriers for the time-of-flight command interpreter.
// Assumes one 20 MHz system clock and parameter bytes loaded before the command strobe.
package tci_pkg;

  // ****************************************************************
  // Command codes and timing
  // ****************************************************************
  localparam logic [7:0]  CMD_START_MEAS  = 8'h02;
  localparam logic [7:0]  CMD_WRITE_CFG   = 8'h08;
  localparam logic [7:0]  CMD_READ_CFG    = 8'h09;
  localparam logic [7:0]  CMD_FACTORY_CAL = 8'h0a;
  localparam logic [7:0]  CMD_AUX_CTRL    = 8'h0f;
  localparam int          CLK_HZ          = 20000000;
  localparam int          LEAD_STEP_US    = 100;
  localparam int          LEAD_STEP_CYC   = (CLK_HZ / 1000000) * LEAD_STEP_US;
  localparam int          MS_CYC          = CLK_HZ / 1000;
  localparam logic [7:0]  PERIOD_CODE_1S  = 8'hfe;
  localparam logic [7:0]  PERIOD_CODE_2S  = 8'hff;
  localparam logic [11:0] PERIOD_1S_MS    = 12'h3e8;
  localparam logic [11:0] PERIOD_2S_MS    = 12'h7d0;
  localparam int          WIN_BYTES       = 14;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          THRESH_MSB      = 5;
  localparam int          SPREAD_LSB      = 6;
  localparam int          MODE_W          = 4;
  localparam logic [3:0]  AUX_RESET_MODE  = 4'h4;

  // Auxiliary pin modes; codes above AUX_OD_LOW_DET are reserved
  localparam logic [3:0]  AUX_DISABLED    = 4'h0;
  localparam logic [3:0]  AUX_GATE_LOW    = 4'h1;
  localparam logic [3:0]  AUX_GATE_HIGH   = 4'h2;
  localparam logic [3:0]  AUX_PULSE       = 4'h3;
  localparam logic [3:0]  AUX_DRIVE_LOW   = 4'h4;
  localparam logic [3:0]  AUX_DRIVE_HIGH  = 4'h5;
  localparam logic [3:0]  AUX_HIGH_DET    = 4'h6;
  localparam logic [3:0]  AUX_LOW_DET     = 4'h7;
  localparam logic [3:0]  AUX_OD_FLOAT_DET = 4'h8;
  localparam logic [3:0]  AUX_OD_LOW_DET  = 4'h9;

  // Parameter bytes written by the host ahead of a command
  typedef struct packed {
    logic [7:0] param_byte_5;
    logic [7:0] param_byte_4;
    logic [7:0] param_byte_3;
    logic [7:0] param_byte_2;
    logic [7:0] param_byte_1;
    logic [7:0] param_byte_0;
  } tci_params_t;

  // One measurement result from the ranging engine
  typedef struct packed {
    logic        detect;
    logic [15:0] distance_mm;
  } tci_result_t;

  typedef logic [WIN_BYTES-1:0][7:0] tci_window_t;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_WAIT, ST_GATED} tci_state_t;

endpackage : tci_pkg

/* logic/tci_command_interpreter.sv */
// Command interpreter of the ranging sensor: decodes host commands, schedules
// measurements, raises interrupts and runs the two auxiliary pins.
// Assumes the ranging engine answers start with one done pulse and owns the emitter.
`timescale 1ns/1ps

// Operation
// R1: Pulse lead 0 gives no signal, 1 rises at pulse start, each step adds 100 us.
// R2: In pulse mode the pin falls when the emitter stops emitting.
// R3: Threshold byte bits 5:0 hold detection threshold; host uses zero by default.
// R4: Bits 7:6 set spread amplitude; host enables it only with clock halving.
// R5: Repeat interval in ms; zero single, 0xfe 1000 ms, 0xff 2000 ms.
// R6: Interval shorter than ranging time repeats as fast as possible.
// R7: Iteration count 16 bits in thousands, low byte 1, high byte 0.
// R8: Each completion sets interrupt flag; pin asserts when pin enable is one.
// R9: Each completion updates the transaction identifier.
// R10: Persistence zero: every result raises an interrupt.
// R11: Persistence 1-255: interrupt only in range after that many consecutive detections.
// R12: Config command takes low limit from bytes 3/2, high limit from 1/0.
// R13: Read config places persistence and both limits at locations 0x20 to 0x24.
// R14: Host loads all measurement parameters before factory calibration.
// R15: Calibration result stored as fourteen bytes from location 0x20.
// R16: Pin control command applies byte 0 pin modes without measuring.
// R17: First pin mode field bits 3:0 with the listed encodings, default drive low.
// R18: Gate assertion aborts the measurement; deassertion starts a fresh one.
// R19: Modes 6 to 9 follow detection, push-pull or open drain.
// R20: Second pin mode field bits 7:4, same encodings.
// R21: Host writes parameter bytes before the command code.
// R22: Pin modes 10 to 15 reserved, treated as disabled.
module tci_command_interpreter
  import tci_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  // Host command port
  input  wire logic         cmd_wr_i,
  input  wire logic [7:0]   cmd_code_i,
  input  wire tci_params_t  params_i,
  input  wire logic         pin_interrupt_enable_i,
  input  wire logic         int_clear_i,
  // Ranging engine
  input  wire logic         meas_done_i,
  input  wire tci_result_t  meas_result_i,
  input  wire tci_window_t  cal_data_i,
  input  wire logic         pulse_req_i,
  input  wire logic         emitter_on_i,
  output logic              meas_start_o,
  output logic              meas_abort_o,
  output logic              cal_mode_o,
  output logic              emitter_fire_o,
  output logic [15:0]       iterations_k_o,
  output logic [5:0]        detect_threshold_o,
  output logic [1:0]        emitter_clock_spread_amplitude_o,
  // Status
  output logic              int_flag_o,
  output logic              int_n_o,
  output logic [7:0]        transaction_id_o,
  output tci_window_t       result_window_o,
  // Auxiliary pins
  input  wire logic [1:0]   aux_in_i,
  output logic [1:0]        aux_out_o,
  output logic [1:0]        aux_oe_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tci_state_t        state_r;
  logic [7:0]        lead_steps_r;
  logic [7:0]        period_code_r;
  logic [7:0]        persistence_r;
  logic [15:0]       low_limit_r;
  logic [15:0]       high_limit_r;
  logic [7:0]        consec_r;
  logic              detect_r;
  logic [1:0][3:0]   aux_mode_r;
  logic [1:0]        gate_act;
  logic              gate_any;
  logic              gate_any_r;
  logic [15:0]       ms_div_r;
  logic [11:0]       ms_elapsed_r;
  logic [11:0]       period_ms;
  logic              ms_tick;
  logic              cmd_start;
  logic              cmd_cal;
  logic              qualify;
  logic [7:0]        consec_nxt;
  logic              int_event;
  logic              lead_busy_r;
  logic [7:0]        lead_left_r;
  logic [10:0]       lead_div_r;
  logic              pulse_hi_r;
  logic              seen_on_r;
  logic              pulse_pin;

  assign cmd_start = cmd_wr_i && (cmd_code_i == CMD_START_MEAS);
  assign cmd_cal   = cmd_wr_i && (cmd_code_i == CMD_FACTORY_CAL);

  // ****************************************************************
  // Measurement parameters
  // ****************************************************************
  // Latched on start or calibration; the host has loaded the bytes first [R21] [R14]
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lead_steps_r                     <= 8'h00;
      detect_threshold_o               <= 6'h00;
      emitter_clock_spread_amplitude_o <= 2'h0;
      period_code_r                    <= 8'h00;
      iterations_k_o                   <= 16'h0000;
    end else if (cmd_start || cmd_cal) begin
      lead_steps_r                     <= params_i.param_byte_4;
      detect_threshold_o               <= params_i.param_byte_3[THRESH_MSB:0]; // [R3]
      emitter_clock_spread_amplitude_o <= params_i.param_byte_3[7:SPREAD_LSB];
      period_code_r                    <= params_i.param_byte_2;
      iterations_k_o                   <= {params_i.param_byte_0, params_i.param_byte_1}; // [R7]
    end
  end

  // Interval decode; the two top codes stand for whole seconds [R5]
  always_comb begin
    if (period_code_r == PERIOD_CODE_1S) begin
      period_ms = PERIOD_1S_MS;
    end else if (period_code_r == PERIOD_CODE_2S) begin
      period_ms = PERIOD_2S_MS;
    end else begin
      period_ms = {4'h0, period_code_r};
    end
  end

  // ****************************************************************
  // Measurement scheduling
  // ****************************************************************
  // Millisecond enable, restarted at every measurement start
  assign ms_tick = (ms_div_r == 16'(MS_CYCLES - 1));
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_div_r     <= 16'h0000;
      ms_elapsed_r <= 12'h000;
    end else if (meas_start_o) begin
      ms_div_r     <= 16'h0000;
      ms_elapsed_r <= 12'h000;
    end else if (ms_tick) begin
      ms_div_r     <= 16'h0000;
      ms_elapsed_r <= (ms_elapsed_r == 12'hfff) ? ms_elapsed_r : ms_elapsed_r + 12'h001;
    end else begin
      ms_div_r     <= ms_div_r + 16'h0001;
    end
  end

  // Gating inputs; an active gate overrides any pending start [R18]
  generate
    for (genvar g = 0; g < 2; g++) begin : g_gate
      assign gate_act[g] = ((aux_mode_r[g] == AUX_GATE_LOW) && !aux_in_i[g]) ||
                           ((aux_mode_r[g] == AUX_GATE_HIGH) && aux_in_i[g]);
    end
  endgenerate
  assign gate_any = |gate_act;

  // Sequencer: start, run, wait for the interval, or sit gated
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r      <= ST_IDLE;
      meas_start_o <= 1'b0;
      meas_abort_o <= 1'b0;
      cal_mode_o   <= 1'b0;
      gate_any_r   <= 1'b0;
    end else begin
      meas_start_o <= 1'b0;
      meas_abort_o <= 1'b0;
      gate_any_r   <= gate_any;
      case (state_r)
        ST_IDLE: begin
          if (cmd_start || cmd_cal) begin
            cal_mode_o <= cmd_cal;
            if (gate_any) begin
              state_r <= ST_GATED;
            end else begin
              meas_start_o <= 1'b1;
              state_r      <= ST_RUN;
            end
          end
        end
        ST_RUN: begin
          if (gate_any) begin
            meas_abort_o <= 1'b1; // Drop the measurement in progress [R18]
            state_r      <= ST_GATED;
          end else if (meas_done_i) begin
            if (cal_mode_o || (period_code_r == 8'h00)) begin
              state_r <= ST_IDLE;
            end else if (ms_elapsed_r >= period_ms) begin
              meas_start_o <= 1'b1; // Overran the interval: go again at once [R6]
            end else begin
              state_r <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (gate_any) begin
            state_r <= ST_GATED;
          end else if (ms_elapsed_r >= period_ms) begin
            meas_start_o <= 1'b1; // [R5]
            state_r      <= ST_RUN;
          end
        end
        default: begin
          if (!gate_any && gate_any_r) begin
            meas_start_o <= 1'b1; // Gate released: fresh measurement [R18]
            state_r      <= ST_RUN;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Interrupt suppression and completion status
  // ****************************************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      persistence_r <= 8'h00;
      low_limit_r   <= 16'h0000;
      high_limit_r  <= 16'hffff;
    end else if (cmd_wr_i && (cmd_code_i == CMD_WRITE_CFG)) begin
      persistence_r <= params_i.param_byte_4;
      low_limit_r   <= {params_i.param_byte_2, params_i.param_byte_3}; // [R12]
      high_limit_r  <= {params_i.param_byte_0, params_i.param_byte_1}; // [R12]
    end
  end

  // In-range detection streak, saturating so a long run never wraps
  assign qualify    = meas_result_i.detect &&
                      (meas_result_i.distance_mm >= low_limit_r) &&
                      (meas_result_i.distance_mm <= high_limit_r);
  assign consec_nxt = qualify ? ((consec_r == 8'hff) ? consec_r : consec_r + 8'h01) : 8'h00;
  assign int_event  = meas_done_i && (state_r == ST_RUN) && !gate_any &&
                      ((persistence_r == 8'h00) ||                            // [R10]
                       (qualify && (consec_nxt >= persistence_r)));           // [R11]

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      consec_r         <= 8'h00;
      detect_r         <= 1'b0;
      transaction_id_o <= 8'h00;
    end else if (meas_done_i && (state_r == ST_RUN) && !gate_any) begin
      consec_r         <= consec_nxt;
      detect_r         <= meas_result_i.detect;
      transaction_id_o <= transaction_id_o + 8'h01; // [R9]
    end
  end

  // Sticky flag; a new event beats a clear in the same cycle [R8]
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_flag_o <= 1'b0;
    end else if (int_event) begin
      int_flag_o <= 1'b1;
    end else if (int_clear_i) begin
      int_flag_o <= 1'b0;
    end
  end
  assign int_n_o = ~(int_flag_o & pin_interrupt_enable_i); // [R8]

  // Result window: configuration readback or calibration record
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_window_o <= '0;
    end else if (cmd_wr_i && (cmd_code_i == CMD_READ_CFG)) begin
      result_window_o[0] <= persistence_r; // Locations 0x20 through 0x24 [R13]
      result_window_o[1] <= low_limit_r[7:0];
      result_window_o[2] <= low_limit_r[15:8];
      result_window_o[3] <= high_limit_r[7:0];
      result_window_o[4] <= high_limit_r[15:8];
    end else if (meas_done_i && (state_r == ST_RUN) && cal_mode_o && !gate_any) begin
      result_window_o <= cal_data_i; // [R15]
    end
  end

  // ****************************************************************
  // Auxiliary pins
  // ****************************************************************
  // Modes from byte 5 on start, byte 0 on pin control (no measurement) [R16] [R17] [R20]
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      aux_mode_r <= {AUX_RESET_MODE, AUX_RESET_MODE};
    end else if (cmd_start) begin
      aux_mode_r <= params_i.param_byte_5;
    end else if (cmd_wr_i && (cmd_code_i == CMD_AUX_CTRL)) begin
      aux_mode_r <= params_i.param_byte_0; // [R16]
    end
  end

  // Lead timer: pin rises at the request, emitter fires after lead-1 steps [R1]
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lead_busy_r    <= 1'b0;
      lead_left_r    <= 8'h00;
      lead_div_r     <= 11'h000;
      emitter_fire_o <= 1'b0;
      pulse_hi_r     <= 1'b0;
    end else begin
      emitter_fire_o <= 1'b0;
      if (pulse_req_i && !lead_busy_r) begin
        if (lead_steps_r <= 8'h01) begin
          emitter_fire_o <= 1'b1;
        end else begin
          lead_busy_r <= 1'b1;
        end
        lead_left_r <= lead_steps_r - 8'h01;
        lead_div_r  <= 11'h000;
        pulse_hi_r  <= (lead_steps_r != 8'h00); // Step 0 means no pin signal [R1]
      end else if (lead_busy_r) begin
        if (lead_div_r == 11'(LEAD_STEP_CYC - 1)) begin
          lead_div_r  <= 11'h000;
          lead_left_r <= lead_left_r - 8'h01;
          if (lead_left_r == 8'h01) begin
            lead_busy_r    <= 1'b0;
            emitter_fire_o <= 1'b1;
          end
        end else begin
          lead_div_r <= lead_div_r + 11'h001;
        end
      end else if (seen_on_r && !emitter_on_i) begin
        pulse_hi_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seen_on_r <= 1'b0;
    end else begin
      seen_on_r <= pulse_hi_r && (emitter_on_i || (seen_on_r && !(pulse_req_i && !lead_busy_r)));
    end
  end
  // Pin drops in the very cycle the emitter goes dark [R2]
  assign pulse_pin = pulse_hi_r && !(seen_on_r && !emitter_on_i);

  // Per-pin output decode; reserved codes behave as disabled [R22]
  generate
    for (genvar g = 0; g < 2; g++) begin : g_aux
      always_comb begin
        aux_out_o[g] = 1'b0;
        aux_oe_o[g]  = 1'b0;
        case (aux_mode_r[g])
          AUX_PULSE:        begin aux_out_o[g] = pulse_pin; aux_oe_o[g] = 1'b1; end // [R1]
          AUX_DRIVE_LOW:    begin aux_out_o[g] = 1'b0;      aux_oe_o[g] = 1'b1; end // [R17]
          AUX_DRIVE_HIGH:   begin aux_out_o[g] = 1'b1;      aux_oe_o[g] = 1'b1; end // [R17]
          AUX_HIGH_DET:     begin aux_out_o[g] = detect_r;  aux_oe_o[g] = 1'b1; end // [R19]
          AUX_LOW_DET:      begin aux_out_o[g] = ~detect_r; aux_oe_o[g] = 1'b1; end // [R19]
          AUX_OD_FLOAT_DET: begin aux_oe_o[g] = ~detect_r; end // [R19]
          AUX_OD_LOW_DET:   begin aux_oe_o[g] = detect_r;  end // [R19]
          default:          begin aux_oe_o[g] = 1'b0;      end // [R22]
        endcase
      end
    end
  endgenerate

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  a_int_pin_follows: assert property (int_n_o == !(int_flag_o && pin_interrupt_enable_i)) // [R8]
    else $error("interrupt pin disagrees with flag and enable");
  a_int_set_wins: assert property (int_event |=> int_flag_o) // [R8]
    else $error("completion did not set interrupt flag");
  a_tid_step: assert property (int_event |=> transaction_id_o == $past(transaction_id_o) + 8'h01) // [R9]
    else $error("transaction id not advanced");
  a_pers_zero_all: assert property (meas_done_i && state_r == ST_RUN && !gate_any && persistence_r == 8'h00
    |=> int_flag_o) // [R10]
    else $error("result without interrupt at zero persistence");
  a_out_range_quiet: assert property (meas_done_i && persistence_r != 8'h00 && !qualify && !int_flag_o
    && !int_clear_i |=> !int_flag_o) // [R11]
    else $error("interrupt raised outside limits");
  a_gate_aborts: assert property (state_r == ST_RUN && gate_any |=> meas_abort_o && state_r == ST_GATED) // [R18]
    else $error("gate did not abort measurement");
  a_ungate_starts: assert property (state_r == ST_GATED && gate_any ##1 !gate_any |=> meas_start_o) // [R18]
    else $error("gate release did not restart");
  a_pulse_falls: assert property (aux_mode_r[0] == AUX_PULSE && $fell(emitter_on_i) |-> !aux_out_o[0]) // [R2]
    else $error("pulse pin high after emitter stopped");
  a_no_lead_pin: assert property (pulse_req_i && !lead_busy_r && lead_steps_r == 8'h00
    |=> emitter_fire_o && !pulse_hi_r) // [R1]
    else $error("lead zero produced a pin signal");
  a_cfg_readback: assert property (cmd_wr_i && cmd_code_i == CMD_READ_CFG
    |=> result_window_o[0] == persistence_r && result_window_o[4] == high_limit_r[15:8]) // [R13]
    else $error("readback window wrong");
  a_aux_ctrl_idle: assert property (cmd_wr_i && cmd_code_i == CMD_AUX_CTRL |=> !meas_start_o) // [R16]
    else $error("pin control started a measurement");

  c_repeat: cover property (meas_done_i && state_r == ST_RUN ##[1:40] meas_start_o);
  c_gated: cover property (meas_abort_o);
  c_cal_done: cover property (cal_mode_o && meas_done_i && state_r == ST_RUN);
  c_lead_fire: cover property (lead_busy_r ##1 emitter_fire_o);

endmodule : tci_command_interpreter

/* tb/tci_engine_model.sv */
// Ranging engine stand-in: answers each unaborted start with one done pulse after LAT cycles.
// Assumes start and abort are one-cycle pulses from the interpreter.
`timescale 1ns/1ps
module tci_engine_model
  import tci_pkg::*;
#(
  parameter int LAT = 2500
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  // Interpreter side
  input  wire logic        start_i,
  input  wire logic        abort_i,
  input  wire tci_result_t next_i,
  output logic             done_o,
  output tci_result_t      result_o,
  output tci_window_t      cal_o
);
  int cnt_r;
  // Countdown per run; an abort drops the run in progress
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r    <= 0;
      done_o   <= 1'b0;
      result_o <= '0;
    end else begin
      done_o   <= 1'b0;
      result_o <= ~result_o; // Not valid off the done pulse, so keep it moving
      if (abort_i) cnt_r <= 0;
      else if (start_i) cnt_r <= LAT;
      else if (cnt_r == 1) begin
        cnt_r    <= 0;
        done_o   <= 1'b1;
        result_o <= next_i;
      end else if (cnt_r > 1) cnt_r <= cnt_r - 1;
    end
  end
  // Calibration record is valid only beside done
  always_comb for (int i = 0; i < WIN_BYTES; i++) cal_o[i] = done_o ? 8'ha0 + 8'(i) : 8'h5a ^ 8'(i);
endmodule : tci_engine_model

/* tb/tb_top.sv */
// Self-checking bench for the command interpreter beside a ranging engine stand-in.
// Assumes a 20 MHz clock; inputs change 5 ns after the rising edge.
`timescale 1ns/1ps
`define TCI_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
  $display("mismatch at %0t ns: got %h want %h", $time, a, b); end end
module tb_top;
  import tci_pkg::*;
  typedef struct packed {logic [7:0] b0; logic [1:0] out; logic [1:0] oe;} tci_row_t;
  logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, cmd_wr_i = 1'b0, int_clear_i = 1'b0, pulse_req_i = 1'b0;
  logic        emitter_on_i = 1'b0, pin_interrupt_enable_i = 1'b1, meas_done_i, meas_start_o, meas_abort_o;
  logic        emitter_fire_o, cal_mode_o, int_flag_o, int_n_o;
  logic [7:0]  cmd_code_i, transaction_id_o;
  logic [15:0] iterations_k_o;
  logic [5:0]  detect_threshold_o;
  logic [1:0]  spread_o, aux_in_i, aux_out_o, aux_oe_o;
  tci_params_t params_i, sp;
  tci_result_t meas_result_i, nxt;
  tci_window_t cal_data_i, result_window_o, exp_win;
  int          errors = 0, tests_run = 0, starts = 0, n;
  tci_row_t    rows [5] = '{'{8'h54, 2'b10, 2'b11}, '{8'h76, 2'b10, 2'b11}, '{8'h98, 2'b00, 2'b01},
                            '{8'ha0, 2'b00, 2'b00}, '{8'h0b, 2'b00, 2'b00}};
  always #25 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) if (meas_start_o === 1'b1) starts++;
  localparam int MS_SIM = 20; // Short millisecond keeps the long intervals affordable
  tci_command_interpreter #(.MS_CYCLES(MS_SIM)) DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cmd_wr_i(cmd_wr_i),
    .cmd_code_i(cmd_code_i), .params_i(params_i), .pin_interrupt_enable_i(pin_interrupt_enable_i),
    .int_clear_i(int_clear_i), .meas_done_i(meas_done_i), .meas_result_i(meas_result_i),
    .cal_data_i(cal_data_i), .pulse_req_i(pulse_req_i), .emitter_on_i(emitter_on_i),
    .meas_start_o(meas_start_o), .meas_abort_o(meas_abort_o), .cal_mode_o(cal_mode_o),
    .emitter_fire_o(emitter_fire_o), .iterations_k_o(iterations_k_o), .detect_threshold_o(detect_threshold_o),
    .emitter_clock_spread_amplitude_o(spread_o), .int_flag_o(int_flag_o), .int_n_o(int_n_o),
    .transaction_id_o(transaction_id_o), .result_window_o(result_window_o), .aux_in_i(aux_in_i),
    .aux_out_o(aux_out_o), .aux_oe_o(aux_oe_o));
  tci_engine_model engine (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .start_i(meas_start_o),
    .abort_i(meas_abort_o), .next_i(nxt), .done_o(meas_done_i), .result_o(meas_result_i), .cal_o(cal_data_i));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys_i);
    #5;
  endtask : cyc
  // Parameters settle a cycle before the code, as the strobe launches the command
  task automatic cmd(input logic [7:0] c, input tci_params_t p);
    params_i = p;
    cyc(1);
    cmd_code_i = c;
    cmd_wr_i = 1'b1;
    cyc(1);
    cmd_wr_i = 1'b0;
  endtask : cmd
  function automatic logic sig(input int s);
    case (s)
      0: return meas_done_i;
      1: return meas_abort_o;
      2: return meas_start_o;
      default: return emitter_fire_o;
    endcase
  endfunction : sig
  // Bounded wait; a hang ends the run with a mismatch
  task automatic wait_for(input int s, output int k);
    for (k = 0; k < 3000 && sig(s) !== 1'b1; k++) cyc(1);
    if (k == 3000) begin
      errors++;
      $display("mismatch at %0t ns: timeout", $time);
      give_verdict();
    end
  endtask : wait_for
  task automatic meas(input logic [15:0] d, input logic det);
    nxt = {det, d};
    cmd(CMD_START_MEAS, sp);
    wait_for(0, n);
    cyc(1);
  endtask : meas
  task automatic clr();
    int_clear_i = 1'b1;
    cyc(1);
    int_clear_i = 1'b0;
  endtask : clr
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    cmd_code_i = 8'h00;
    params_i = '0;
    aux_in_i = 2'b00;
    nxt = '0;
    sp = {8'h54, 8'h00, 8'h3f, 8'h00, 8'h34, 8'h12}; // Spread left off, halving unknown
    repeat (6) @(posedge clk_sys_i);
    #5 rst_n_i = 1'b1;
    `TCI_CHK({aux_oe_o, aux_out_o}, 4'hc)
    `TCI_CHK({int_n_o, transaction_id_o}, 9'h100)
    foreach (rows[i]) begin
      cmd(CMD_AUX_CTRL, {40'h0, rows[i].b0});
      cyc(1);
      `TCI_CHK({aux_oe_o, aux_out_o & aux_oe_o}, {rows[i].oe, rows[i].out})
    end
    `TCI_CHK(starts, 0)
    $display("test pin table done");
    meas(16'h0000, 1'b0);
    `TCI_CHK({iterations_k_o, detect_threshold_o, spread_o}, 24'h1234fc)
    `TCI_CHK({int_flag_o, int_n_o, transaction_id_o}, 10'h201)
    pin_interrupt_enable_i = 1'b0;
    #1 `TCI_CHK(int_n_o, 1'b1)
    pin_interrupt_enable_i = 1'b1;
    $display("test start done");
    cmd(CMD_WRITE_CFG, {8'h00, 8'h02, 8'h64, 8'h00, 8'hc8, 8'h00});
    cmd(CMD_READ_CFG, '0);
    cyc(1);
    `TCI_CHK(result_window_o[4:0], 40'h00c8006402)
    clr();
    meas(16'd100, 1'b1);
    `TCI_CHK({int_flag_o, transaction_id_o}, 9'h002)
    meas(16'd200, 1'b1);
    `TCI_CHK(int_flag_o, 1'b1)
    clr();
    meas(16'd201, 1'b1);
    `TCI_CHK({int_flag_o, transaction_id_o}, 9'h004)
    cmd(CMD_AUX_CTRL, {40'h0, 8'h98});
    cyc(1);
    `TCI_CHK({aux_oe_o, aux_out_o & aux_oe_o}, 4'h8)
    cmd(CMD_AUX_CTRL, {40'h0, 8'h76});
    cyc(1);
    `TCI_CHK(aux_out_o, 2'b01)
    $display("test persistence done");
    cmd(CMD_FACTORY_CAL, sp); // Same parameter load as a start
    `TCI_CHK(cal_mode_o, 1'b1)
    wait_for(0, n);
    cyc(1);
    for (int i = 0; i < WIN_BYTES; i++) exp_win[i] = 8'ha0 + 8'(i);
    `TCI_CHK(result_window_o, exp_win)
    sp.param_byte_5 = 8'h42;
    cmd(CMD_START_MEAS, sp);
    cyc(3);
    aux_in_i = 2'b01;
    wait_for(1, n);
    `TCI_CHK(n <= 1, 1'b1)
    aux_in_i = 2'b00;
    wait_for(2, n);
    `TCI_CHK(n <= 2, 1'b1)
    wait_for(0, n);
    cyc(1);
    $display("test calibration and gating done");
    for (int l = 0; l < 3; l++) begin
      cmd(CMD_START_MEAS, {8'h43, 8'(l), 32'h1});
      pulse_req_i = 1'b1;
      cyc(1);
      pulse_req_i = 1'b0;
      wait_for(3, n);
      `TCI_CHK(n, (l <= 1) ? 0 : (l - 1) * LEAD_STEP_CYC)
      `TCI_CHK(aux_out_o[0], l >= 1)
      emitter_on_i = 1'b1;
      cyc(2);
      emitter_on_i = 1'b0;
      #1 `TCI_CHK(aux_out_o[0], 1'b0)
      wait_for(0, n);
      cyc(1);
    end
    $display("test pulse lead done");
    cmd(CMD_START_MEAS, {8'h54, 8'h00, 8'h00, 8'h01, 16'h0001});
    wait_for(0, n);
    cyc(1);
    wait_for(2, n);
    `TCI_CHK(n <= 1, 1'b1)
    $display("test repeat done");
    rst_n_i = 1'b0; // Mid-run reset ends the repeat loop; a start with a zero interval would also end it
    cyc(2);
    rst_n_i = 1'b1;
    `TCI_CHK({int_flag_o, transaction_id_o, aux_oe_o, aux_out_o}, 13'h00c)
    cmd(CMD_START_MEAS, {8'h54, 8'h00, 8'h00, PERIOD_CODE_1S, 16'h0001});
    cyc(1);
    for (n = 1; n < 21000 && meas_start_o !== 1'b1; n++) cyc(1);
    `TCI_CHK(n >= PERIOD_1S_MS * MS_SIM && n <= PERIOD_1S_MS * MS_SIM + 2, 1'b1)
    $display("test reset and long interval done");
    give_verdict();
  end
endmodule : tb_top
